/* File: include/bpa_pkg.sv */
package bpa_pkg;
	// Clock and sleep-clock timing
	localparam int CLK_HZ = 100_000_000;
	localparam int SLEEP_HZ = 32768;
	localparam int SLEEP_DIV = CLK_HZ / SLEEP_HZ;
	localparam int TENTH_MS = 100;
	localparam int TENTH_TICKS = SLEEP_HZ * TENTH_MS / 1000;
	localparam int TENTHS_PER_SEC = 10;
	// Packet shape
	localparam logic [3:0] LAST_FIELD = 4'he;
	localparam logic [3:0] HEADER_FIELD = 4'h0;
	localparam logic [3:0] MAX_BYTES = 4'h8;
	localparam int DATA_FIELDS = 14;
	localparam int SENSOR_SLOTS = 8;
	localparam int EXT_CHANNELS = 4;
	localparam int ADC_BITS = 11;
	localparam int ADC_MAX_KSPS = 64;
	// Reset values
	localparam logic [63:0] LFSR_SEED = 64'h0123_4567_89ab_cdef;
	localparam logic [31:0] DOWN_RESET = 32'hffff_ffff;
	// Source type of a data field
	typedef enum logic [3:0] {
		SRC_FIXED = 4'h0,
		SRC_TIMER = 4'h1,
		SRC_RANDOM = 4'h2,
		SRC_INTERNAL = 4'h3,
		SRC_EXTANALOG = 4'h4,
		SRC_UID = 4'h5,
		SRC_EPHID = 4'h6,
		SRC_AUTHTAG = 4'h7,
		SRC_TALLY = 4'h8,
		SRC_SLEEPCNT = 4'h9,
		SRC_PINS = 4'ha,
		SRC_PULSE = 4'hb,
		SRC_REGVAL = 4'hc,
		SRC_SENSOR = 4'hd
	} bpa_src_type;
	// Timer options
	localparam logic [1:0] TMR_UP = 2'h0;
	localparam logic [1:0] TMR_DOWN = 2'h1;
	localparam logic [1:0] TMR_TENTH = 2'h2;
	localparam logic [1:0] TMR_SEC = 2'h3;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOAD = 2'b01,
		ST_SEND = 2'b10
	} bpa_state_type;
	typedef struct packed {
		bpa_state_type st;
		logic [3:0] field;
		logic [3:0] byteIdx;
		logic [3:0] curLen;
		logic [63:0] curVal;
		logic [7:0] outByte;
		logic outValid;
		logic packetDone;
		logic busy;
		logic [11:0] divCnt;
		logic [63:0] upTimer;
		logic [31:0] downTimer;
		logic [11:0] tenthPre;
		logic [3:0] secPre;
		logic [31:0] elapsedTenths;
		logic [31:0] elapsedSecs;
		logic [63:0] lfsr;
		logic [7:0] pinS1;
		logic [7:0] pinS2;
		logic [7:0] pinWake;
		logic pulseS1;
		logic pulseS2;
		logic pulsePrev;
		logic [15:0] hiCnt;
		logic [15:0] loCnt;
		logic [31:0] pulseBits;
		logic [31:0] pulseCount;
		logic [31:0] advertEventTally;
		logic [31:0] sleepCount;
		logic [7:0][15:0] sensorMem;
		logic [63:0] snUp;
		logic [31:0] snDown;
		logic [31:0] snTenths;
		logic [31:0] snSecs;
		logic [63:0] snRand;
		logic [10:0] snTemp;
		logic [10:0] snVcc;
		logic [3:0][10:0] snExt;
		logic [63:0] snEph;
		logic [63:0] snTag;
		logic [31:0] snTally;
		logic [31:0] snSleep;
		logic [7:0] snPinCur;
		logic [7:0] snPinWake;
		logic [31:0] snPulseW;
		logic [31:0] snPulseC;
		logic [31:0] snReg;
		logic [7:0][15:0] snSensor;
	} bpa_regs_type;
endpackage

/* File: rtl/bpa_payload_assembler.sv */
`timescale 1ns/1ps
// Behaviour
// - A packet holds at most fifteen fields, indices zero to fourteen.
// - Field zero carries only the header and address bytes.
// - Each of the fourteen data fields carries one configured source type.
// - Fixed fields take bytes and length from read-only programmed memory.
// - Timer field: raw up or down timer, or elapsed count in 0.1 s or 1 s.
// - Random field inserts the shift register generator value.
// - The random value is offered as salt for authenticated encryption.
// - Internal field inserts converter result for die temperature or supply.
// - External analog field inserts converter result from pins four to seven.
// - Identifier field inserts maker or customer unique identifier.
// - Ephemeral identifier field inserts the rotating identifier value.
// - Authentication field inserts the authenticated encryption tag.
// - Event counter field inserts the advertising event tally.
// - Sleep count field inserts sleep entries since power-up.
// - Pin field inserts present pin levels or levels latched at wake-up.
// - Pulse field inserts pulse-width bits or pulse-train count.
// - Register field inserts a register value read at build time.
// - Two-wire sensor readback values are stored for later broadcast.
// - Pulse-width mode decodes each pulse high/low ratio to one bit.
// - Converter results are eleven bits, at most 64 KSPS.
// - Converter multiplexer offers four external channels plus internal ones.
// - Random source is a 64-bit linear feedback shift register.
// - Sleep-clock timers: 32-bit down-counter and 64-bit up-counter.
module bpa_payload_assembler
	import bpa_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Event control
	input wire logic advStart,
	input wire logic sleepEntry,
	input wire logic wakeEvent,
	// Field configuration
	input wire logic [63:0] headerData,
	input wire logic [3:0] headerLen,
	input wire logic [13:0][3:0] cfgType,
	input wire logic [13:0][1:0] cfgOpt,
	input wire logic [13:0][3:0] cfgLen,
	input wire logic [13:0][2:0] cfgSensorSlot,
	// Programmed memory contents
	input wire logic [13:0][63:0] fixedData,
	input wire logic [13:0][3:0] fixedLen,
	input wire logic [63:0] makerUid,
	input wire logic [63:0] customerUid,
	// Computed sources
	input wire logic [63:0] ephemeralIdentifier,
	input wire logic [63:0] authTag,
	input wire logic [31:0] regValue,
	input wire logic seedLoad,
	input wire logic [63:0] seedValue,
	// Converter results
	input wire logic [10:0] adcTemp,
	input wire logic [10:0] adcVcc,
	input wire logic [3:0][10:0] adcMixedSignalPin,
	// Two-wire readback store
	input wire logic sensorWr,
	input wire logic [2:0] sensorWrIdx,
	input wire logic [15:0] sensorWrData,
	// External pins
	input wire logic [7:0] gpioPins,
	input wire logic pulsePin,
	// Payload stream
	input wire logic outReady,
	output logic [7:0] outByte,
	output logic outValid,
	output logic packetDone,
	output logic busy,
	output logic [63:0] randSalt
);

	bpa_regs_type r;
	bpa_regs_type next_r;
	logic sleepTick;
	logic [63:0] selVal;
	logic [3:0] selLen;
	logic [3:0] dIdx;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// Pick one byte of a field value, least significant first
	function automatic logic [7:0] byteOf(input logic [63:0] v,
		input logic [3:0] i);
		byteOf = v[{i[2:0], 3'h0} +: 8];
	endfunction

	// Limit a configured length to the widest value held
	function automatic logic [3:0] capLen(input logic [3:0] l);
		capLen = (l > MAX_BYTES) ? MAX_BYTES : l;
	endfunction

	assign sleepTick = (r.divCnt == 12'(SLEEP_DIV - 1));
	assign dIdx = (r.field == HEADER_FIELD) ? 4'h0 : r.field - 4'h1;

	// Value and length of the field being loaded
	always_comb
	begin
		selVal = 64'h0;
		selLen = capLen(cfgLen[dIdx]);
		if (r.field == HEADER_FIELD)
		begin
			selVal = headerData;
			selLen = capLen(headerLen);
		end
		else
		begin
			case (bpa_src_type'(cfgType[dIdx]))
				SRC_FIXED:
				begin
					selVal = fixedData[dIdx];
					selLen = capLen(fixedLen[dIdx]);
				end
				SRC_TIMER:
					case (cfgOpt[dIdx])
						TMR_UP: selVal = r.snUp;
						TMR_DOWN: selVal = {32'h0, r.snDown};
						TMR_TENTH: selVal = {32'h0, r.snTenths};
						default: selVal = {32'h0, r.snSecs};
					endcase
				SRC_RANDOM: selVal = r.snRand;
				SRC_INTERNAL: selVal = {53'h0, cfgOpt[dIdx][0] ? r.snVcc :
					r.snTemp};
				SRC_EXTANALOG: selVal = {53'h0, r.snExt[cfgOpt[dIdx]]};
				SRC_UID: selVal = cfgOpt[dIdx][0] ? customerUid :
					makerUid;
				SRC_EPHID: selVal = r.snEph;
				SRC_AUTHTAG: selVal = r.snTag;
				SRC_TALLY: selVal = {32'h0, r.snTally};
				SRC_SLEEPCNT: selVal = {32'h0, r.snSleep};
				SRC_PINS: selVal = {56'h0, cfgOpt[dIdx][0] ? r.snPinWake :
					r.snPinCur};
				SRC_PULSE: selVal = {32'h0, cfgOpt[dIdx][0] ? r.snPulseC :
					r.snPulseW};
				SRC_REGVAL: selVal = {32'h0, r.snReg};
				SRC_SENSOR: selVal = {48'h0,
					r.snSensor[cfgSensorSlot[dIdx]]};
				default: selLen = 4'h0;
			endcase
		end
	end

	// Next state of every register
	always_comb
	begin
		next_r = r;
		next_r.packetDone = 1'b0;
		// Sleep-clock enable and always-on timers
		next_r.divCnt = sleepTick ? 12'h0 : r.divCnt + 12'h1;
		if (sleepTick)
		begin
			next_r.upTimer = r.upTimer + 64'h1;
			if (r.downTimer != 32'h0)
				next_r.downTimer = r.downTimer - 32'h1;
			if (r.tenthPre == 12'(TENTH_TICKS - 1))
			begin
				next_r.tenthPre = 12'h0;
				next_r.elapsedTenths = r.elapsedTenths + 32'h1;
				next_r.secPre = (r.secPre == 4'(TENTHS_PER_SEC - 1)) ? 4'h0 :
					r.secPre + 4'h1;
				if (r.secPre == 4'(TENTHS_PER_SEC - 1))
					next_r.elapsedSecs = r.elapsedSecs + 32'h1;
			end
			else
				next_r.tenthPre = r.tenthPre + 12'h1;
		end
		// Random generator, taps 64 63 61 60
		if (seedLoad && seedValue != 64'h0)
			next_r.lfsr = seedValue;
		else
			next_r.lfsr = {r.lfsr[62:0], r.lfsr[63] ^ r.lfsr[62] ^
				r.lfsr[60] ^ r.lfsr[59]};
		// Pin synchronisers and wake latch
		next_r.pinS1 = gpioPins;
		next_r.pinS2 = r.pinS1;
		if (wakeEvent)
			next_r.pinWake = r.pinS2;
		next_r.pulseS1 = pulsePin;
		next_r.pulseS2 = r.pulseS1;
		next_r.pulsePrev = r.pulseS2;
		// Pulse width and pulse train measurement
		if (r.pulseS2 && !r.pulsePrev)
		begin
			next_r.pulseCount = r.pulseCount + 32'h1;
			if (r.hiCnt != 16'h0)
				next_r.pulseBits = {r.pulseBits[30:0],
					r.hiCnt > r.loCnt};
			next_r.hiCnt = 16'h1;
			next_r.loCnt = 16'h0;
		end
		else if (r.pulseS2)
			next_r.hiCnt = (r.hiCnt == 16'hffff) ? r.hiCnt : r.hiCnt + 16'h1;
		else if (r.loCnt != 16'hffff)
			next_r.loCnt = r.loCnt + 16'h1;
		// Counters and readback store
		if (sleepEntry)
			next_r.sleepCount = r.sleepCount + 32'h1;
		if (sensorWr)
			next_r.sensorMem[sensorWrIdx] = sensorWrData;
		// Packet assembly sequence
		case (r.st)
			ST_IDLE:
				if (advStart)
				begin
					next_r.advertEventTally = r.advertEventTally + 32'h1;
					next_r.snUp = r.upTimer;
					next_r.snDown = r.downTimer;
					next_r.snTenths = r.elapsedTenths;
					next_r.snSecs = r.elapsedSecs;
					next_r.snRand = r.lfsr;
					next_r.snTemp = adcTemp;
					next_r.snVcc = adcVcc;
					next_r.snExt = adcMixedSignalPin;
					next_r.snEph = ephemeralIdentifier;
					next_r.snTag = authTag;
					next_r.snTally = r.advertEventTally + 32'h1;
					next_r.snSleep = r.sleepCount;
					next_r.snPinCur = r.pinS2;
					next_r.snPinWake = r.pinWake;
					next_r.snPulseW = r.pulseBits;
					next_r.snPulseC = r.pulseCount;
					next_r.snReg = regValue;
					next_r.snSensor = r.sensorMem;
					next_r.field = HEADER_FIELD;
					next_r.st = ST_LOAD;
				end
			ST_LOAD:
			begin
				next_r.curVal = selVal;
				next_r.curLen = selLen;
				next_r.byteIdx = 4'h0;
				if (selLen != 4'h0)
				begin
					next_r.outByte = byteOf(selVal, 4'h0);
					next_r.outValid = 1'b1;
					next_r.st = ST_SEND;
				end
				else if (r.field == LAST_FIELD)
				begin
					next_r.packetDone = 1'b1;
					next_r.st = ST_IDLE;
				end
				else
					next_r.field = r.field + 4'h1;
			end
			ST_SEND:
				if (outReady)
				begin
					if (r.byteIdx + 4'h1 < r.curLen)
					begin
						next_r.byteIdx = r.byteIdx + 4'h1;
						next_r.outByte = byteOf(r.curVal,
							r.byteIdx + 4'h1);
					end
					else
					begin
						next_r.outValid = 1'b0;
						if (r.field == LAST_FIELD)
						begin
							next_r.packetDone = 1'b1;
							next_r.st = ST_IDLE;
						end
						else
						begin
							next_r.field = r.field + 4'h1;
							next_r.st = ST_LOAD;
						end
					end
				end
			default: next_r.st = ST_IDLE;
		endcase
		next_r.busy = (next_r.st != ST_IDLE); // Registered copy of state
	end

	// State register
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			r <= '0;
			r.lfsr <= LFSR_SEED;
			r.downTimer <= DOWN_RESET;
		end
		else
			r <= next_r;
	end

	assign outByte = r.outByte;
	assign outValid = r.outValid;
	assign packetDone = r.packetDone;
	assign busy = r.busy;
	assign randSalt = r.snRand;
	// Assembly steps
	sequence sAccept;
		r.st == ST_IDLE && advStart;
	endsequence
	sequence sHeaderLoad;
		r.st == ST_LOAD && r.field == HEADER_FIELD;
	endsequence
	a_field_bound: assert property (r.field <= LAST_FIELD)
		else $error("field index beyond fourteen");
	a_done_last: assert property ($rose(r.packetDone) |->
		$past(r.field) == LAST_FIELD) else $error("packet ended early");
	a_header_first: assert property (sAccept |=> sHeaderLoad)
		else $error("packet did not start at header field");
	a_header_len: assert property (sHeaderLoad ##1 r.st == ST_SEND |->
		r.curLen == capLen($past(headerLen)))
		else $error("header length wrong");
	a_tally_step: assert property (sAccept |=>
		r.snTally == $past(r.advertEventTally) + 32'h1)
		else $error("event tally not advanced");
	a_snap_hold: assert property (r.busy && $past(r.busy) |->
		$stable(r.snRand) && $stable(r.snUp) && $stable(r.snReg))
		else $error("snapshot changed during assembly");
	a_salt_match: assert property (sAccept |=>
		randSalt == $past(r.lfsr))
		else $error("salt differs from random value");
	a_lfsr_runs: assert property (!seedLoad |=>
		r.lfsr != $past(r.lfsr))
		else $error("random generator stalled");
	a_sensor_store: assert property (sensorWr |=>
		r.sensorMem[$past(sensorWrIdx)] == $past(sensorWrData))
		else $error("readback value not stored");
	a_byte_order: assert property (r.st == ST_SEND && outReady &&
		r.byteIdx + 4'h1 < r.curLen |=> r.outValid &&
		r.outByte == byteOf(r.curVal, $past(r.byteIdx) + 4'h1))
		else $error("byte order broken");
	a_byte_hold: assert property (r.outValid && !outReady |=>
		r.outValid && $stable(r.outByte))
		else $error("byte dropped while stalled");
	a_up_tick: assert property (sleepTick |=>
		r.upTimer == $past(r.upTimer) + 64'h1)
		else $error("up timer missed sleep tick");

endmodule // bpa_payload_assembler

/* File: testbench/bpa_payload_assembler_bench.sv */
`timescale 1ns/1ps
module bpa_payload_assembler_bench;
	import bpa_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic advStart = 1'b0, sleepEntry = 1'b0, wakeEvent = 1'b0;
	logic [63:0] headerData = '0, makerUid, customerUid, ephId, authTag;
	logic [3:0] headerLen = '0;
	logic [13:0][3:0] cfgType, cfgLen, fixedLen;
	logic [13:0][1:0] cfgOpt = '0;
	logic [13:0][2:0] cfgSensorSlot = '0;
	logic [13:0][63:0] fixedData = '0;
	logic [31:0] regValue = 32'h1234_5678;
	logic seedLoad = 1'b0, sensorWr = 1'b0, pulsePin = 1'b0, slow = 1'b0;
	logic [63:0] seedValue = 64'h0;
	logic [10:0] adcTemp = 11'h5a3, adcVcc = 11'h2b4;
	logic [3:0][10:0] adcPin = '0;
	logic [2:0] sensorWrIdx = '0;
	logic [15:0] sensorWrData = '0;
	logic [7:0] gpioPins = 8'ha5;
	logic outReady, outValid, packetDone, busy;
	logic [7:0] outByte;
	logic [63:0] randSalt;
	logic [7:0] exp[$];
	int errCount = 0;
	int cmpCount = 0;
	always #5 clock = ~clock;
	bpa_payload_assembler u_bpa_payload_assembler (.clock(clock), .rst(rst),
		.advStart(advStart), .sleepEntry(sleepEntry), .wakeEvent(wakeEvent),
		.headerData(headerData), .headerLen(headerLen), .cfgType(cfgType),
		.cfgOpt(cfgOpt), .cfgLen(cfgLen), .cfgSensorSlot(cfgSensorSlot),
		.fixedData(fixedData), .fixedLen(fixedLen), .makerUid(makerUid),
		.customerUid(customerUid), .ephemeralIdentifier(ephId),
		.authTag(authTag), .regValue(regValue), .seedLoad(seedLoad),
		.seedValue(seedValue), .adcTemp(adcTemp), .adcVcc(adcVcc),
		.adcMixedSignalPin(adcPin), .sensorWr(sensorWr),
		.sensorWrIdx(sensorWrIdx), .sensorWrData(sensorWrData),
		.gpioPins(gpioPins), .pulsePin(pulsePin), .outReady(outReady),
		.outByte(outByte), .outValid(outValid), .packetDone(packetDone),
		.busy(busy), .randSalt(randSalt));
	bpa_radio_sink u_bpa_radio_sink (.clock(clock), .outByte(outByte),
		.outValid(outValid), .slow(slow), .outReady(outReady));
	// Verdict and end of run
	task automatic finishTest();
		$display("errors %0d compares %0d", errCount, cmpCount);
		if (errCount == 0 && cmpCount > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Compare one byte
	task automatic check8(input logic [7:0] got, input logic [7:0] want);
		cmpCount++;
		if (got !== want)
		begin
			errCount++;
			$display("BAD %0t byte %h want %h", $time, got, want);
		end
	endtask
	// Compare a flag
	task automatic checkBit(input logic got, input logic want);
		cmpCount++;
		if (got !== want)
		begin
			errCount++;
			$display("BAD %0t flag %b want %b", $time, got, want);
		end
	endtask
	// Queue the low n bytes of a value, least significant first
	task automatic push(input logic [63:0] v, input int n);
		for (int i = 0; i < n; i++)
			exp.push_back(v[8*i +: 8]);
	endtask
	// Run one event, disturb sources and start mid-way, then judge bytes
	task automatic runEvent(input int tail);
		int n;
		u_bpa_radio_sink.got.delete();
		advStart = 1'b1;
		@(negedge clock);
		advStart = 1'b0;
		repeat (4) @(negedge clock);
		checkBit(busy, 1'b1);
		adcTemp = 11'h000;
		regValue = 32'hdead_0000;
		advStart = 1'b1;
		@(negedge clock);
		advStart = 1'b0;
		n = 0;
		while (packetDone !== 1'b1 && n < 2000)
		begin
			@(negedge clock);
			n++;
		end
		if (n >= 2000)
		begin
			errCount++;
			$display("BAD %0t packet never finished", $time);
			finishTest();
		end
		checkBit(busy, 1'b0);
		@(negedge clock);
		checkBit(busy, 1'b0);
		checkBit(u_bpa_radio_sink.got.size() == exp.size() + tail,
			1'b1);
		foreach (exp[i])
			if (i < u_bpa_radio_sink.got.size())
				check8(u_bpa_radio_sink.got[i], exp[i]);
	endtask
	// Every source type but timer and pulse in one packet, slow sink, sources moved mid-event
	task automatic scenarioAllSources();
		logic [13:0][3:0] t;
		slow = 1'b1;
		t = {4'h2, 4'hd, 4'hc, 4'ha, 4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h5,
			4'h4, 4'h3, 4'h3, 4'h0};
		cfgType = t;
		cfgLen = {4'h8, 4'h2, 4'h4, 4'h1, 4'h4, 4'h4, 4'h8, 4'h8, 4'h8,
			4'hf, 4'h2, 4'h2, 4'h2, 4'h8};
		cfgOpt[2] = 2'h1;
		cfgOpt[3] = 2'h2;
		cfgOpt[5] = 2'h1;
		cfgSensorSlot[12] = 3'h5;
		fixedData[0] = 64'h99_8877_6655_4433_22;
		fixedLen[0] = 4'h2;
		headerData = 64'h00c3_b2a1;
		headerLen = 4'h3;
		exp.delete();
		push(headerData, 3);
		push(64'h3322, 2);
		push({53'h0, adcTemp}, 2);
		push({53'h0, adcVcc}, 2);
		push({53'h0, adcPin[2]}, 2);
		push(makerUid, 8);
		push(customerUid, 8);
		push(ephId, 8);
		push(authTag, 8);
		push(64'h1, 4);
		push(64'h3, 4);
		push(64'h3c, 1);
		push({32'h0, regValue}, 4);
		push(64'hbeef, 2);
		runEvent(8);
		for (int i = 0; i < 8; i++)
			check8(u_bpa_radio_sink.got[58 + i], randSalt[8*i +: 8]);
		checkBit(randSalt !== 64'h0, 1'b1);
		adcTemp = 11'h5a3;
	endtask
	// Full header, wake pins, second tally, timers, pulses, empty tail
	task automatic scenarioSecondEvent();
		slow = 1'b0;
		cfgType = {{6{4'hf}}, 4'h1, 4'hb, 4'hb, 4'h1, 4'h1, 4'h1, 4'ha,
			4'h8};
		cfgLen = {{6{4'h3}}, 4'h8, 4'h4, 4'h1, 4'h4, 4'h2, 4'h4, 4'h1,
			4'h4};
		cfgOpt = '0;
		cfgOpt[1] = 2'h1;
		cfgOpt[2] = 2'h2;
		cfgOpt[3] = 2'h3;
		cfgOpt[4] = 2'h1;
		cfgOpt[6] = 2'h1;
		headerData = 64'h8877_6655_4433_2211;
		headerLen = 4'h8;
		// Let exactly one sleep tick pass so both timers leave reset
		repeat (SLEEP_DIV) @(negedge clock);
		// Long high then short high, each closed by the following rise
		pulsePin = 1'b1;
		repeat (3) @(negedge clock);
		pulsePin = 1'b0;
		@(negedge clock);
		pulsePin = 1'b1;
		@(negedge clock);
		pulsePin = 1'b0;
		repeat (3) @(negedge clock);
		pulsePin = 1'b1;
		@(negedge clock);
		pulsePin = 1'b0;
		repeat (4) @(negedge clock);
		exp.delete();
		push(headerData, 8);
		push(64'h2, 4);
		push(64'ha5, 1);
		push(64'h0, 4);
		push(64'h0, 2);
		push({32'h0, DOWN_RESET - 32'h1}, 4);
		push(64'h2, 1);
		push(64'h3, 4);
		push(64'h1, 8);
		runEvent(0);
	endtask
	initial
	begin
		makerUid = 64'h0102_0304_0506_0708;
		customerUid = 64'hf1e2_d3c4_b5a6_9788;
		ephId = 64'h1357_9bdf_2468_ace0;
		authTag = 64'h0fed_cba9_8765_4321;
		adcPin = {11'h7ff, 11'h1c7, 11'h011, 11'h222};
		cfgType = {14{4'hf}};
		cfgLen = '0;
		fixedLen = '0;
		repeat (16) @(negedge clock);
		rst = 1'b0;
		checkBit(outValid, 1'b0);
		checkBit(randSalt === 64'h0, 1'b1);
		// Readback store, sleep entries and wake latch
		sensorWr = 1'b1;
		sensorWrIdx = 3'h5;
		sensorWrData = 16'hbeef;
		@(negedge clock);
		sensorWr = 1'b0;
		sleepEntry = 1'b1;
		repeat (3) @(negedge clock);
		sleepEntry = 1'b0;
		repeat (4) @(negedge clock);
		wakeEvent = 1'b1;
		@(negedge clock);
		wakeEvent = 1'b0;
		gpioPins = 8'h3c;
		repeat (4) @(negedge clock);
		scenarioAllSources();
		scenarioSecondEvent();
		finishTest();
	end
endmodule // bpa_payload_assembler_bench

/* File: testbench/bpa_radio_sink.sv */
`timescale 1ns/1ps
module bpa_radio_sink
(
	// Clock
	input wire logic clock,
	// Payload stream
	input wire logic [7:0] outByte,
	input wire logic outValid,
	input wire logic slow,
	output logic outReady
);
	logic [7:0] got[$];
	int phase = 0;
	initial outReady = 1'b0;
	// Stall one cycle in three when slow, so held bytes get exercised
	always @(negedge clock)
	begin
		phase = (phase + 1) % 3;
		outReady <= !(slow && phase == 0);
	end
	// Keep a byte only at an edge where the handshake completes
	always @(posedge clock)
	begin
		if (outValid === 1'b1 && outReady)
			got.push_back(outByte);
	end
endmodule // bpa_radio_sink
